// ==== pfc_cmd_regs.sv ====
/*
 * Command registers of the three controller functions, with the parity
 * flag of each status word, access claim gating and master gating.
 * Assumes the bus interface decodes configuration cycles into the cfg_*
 * strobes below and presents target accesses and master requests as
 * one-cycle strobes synchronous to mclk.
 */
`timescale 1ns/1ps
// Function
// RULE1 - command all zero: only configuration accesses are claimed.
// RULE2 - sixteen-bit command at configuration offset 04h, resets to zero.
// RULE3 - software writes zero into reserved bits 15 to 10.
// RULE4 - bit 9 read/write; one allows fast back-to-back to other agents.
// RULE5 - software sets bit 9 only when every target supports it.
// RULE6 - bit 8 enables the system-error driver; resets to zero.
// RULE7 - address parity errors reported only when bits 8 and 6 set.
// RULE8 - stepping bit 7 is read-only zero.
// RULE9 - bit 6 set: normal parity error action including error pin.
// RULE10 - bit 6 clear: flag still set, error pin quiet, operation goes on.
// RULE11 - parity always generated regardless of bit 6.
// RULE12 - palette snoop bit 5 is read-only zero.
// RULE13 - bit 2 clear: function starts no bus access; set allows mastering.
// RULE14 - bit 1 gates response to memory space accesses.
// RULE15 - bit 0 gates response to I/O space accesses.
// RULE16 - bit 4 clear: plain writes; set allows write-and-invalidate.
// RULE17 - writes to bits 7, 5 and 3 ignored; they read zero.
// RULE18 - each function keeps its own copy through its own config cycles.
module pfc_cmd_regs
	import pfc_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [1:0] cfg_func,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_rvalid,
	input wire logic acc_valid,
	input wire logic [1:0] acc_func,
	input wire pfc_pkg::pfc_acc_t acc_kind,
	output logic acc_claim,
	output logic [1:0] acc_claim_func,
	input wire logic mst_req,
	input wire logic mst_mwi_req,
	input wire logic [1:0] mst_func,
	output logic mst_go,
	output logic mst_use_mwi,
	output logic [2:0] io_space_en,
	output logic [2:0] memory_space_en,
	output logic [2:0] master_en,
	output logic [2:0] write_invalidate_en,
	output logic [2:0] parity_err_response,
	output logic [2:0] system_error_drive_en,
	output logic [2:0] back_to_back_en,
	output logic [2:0] detected_parity_flag,
	input wire logic [31:0] ad,
	input wire logic [3:0] cbe,
	input wire logic par_in,
	input wire logic addr_phase,
	input wire logic data_phase,
	input wire logic [1:0] phase_func,
	output logic par_o,
	output logic perr_n_o,
	output logic perr_oe,
	output logic serr_n_o,
	output logic serr_oe
);
	import pfc_pkg::*;

	typedef struct packed {
		logic [2:0][15:0] cmd;
		logic [2:0] flag;
		logic [31:0] rdata;
		logic rvalid;
		logic claim;
		logic [1:0] claim_func;
		logic go;
		logic mwi;
	} pfc_state_t;

	pfc_state_t s_q, s_d;
	logic [2:0] flag_set;
	logic [2:0] resp_vec;
	logic [2:0] serr_vec;
	logic hit;
	logic [15:0] wmask;
	logic [15:0] acmd;
	logic [15:0] mcmd;

	// per-function enables feed the checker straight from the registers
	always_comb begin
		for (int f = 0; f < NUM_FUNC; f++) begin
			resp_vec[f] = s_q.cmd[f][RESP_BIT];
			serr_vec[f] = s_q.cmd[f][SERR_BIT];
		end
	end

	pfc_parity u_parity (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.ad(ad),
		.cbe(cbe),
		.par_in(par_in),
		.addr_phase(addr_phase),
		.data_phase(data_phase),
		.phase_func(phase_func),
		.resp_en(resp_vec),
		.serr_en(serr_vec),
		.par_o(par_o),
		.perr_n_o(perr_n_o),
		.perr_oe(perr_oe),
		.serr_n_o(serr_n_o),
		.serr_oe(serr_oe),
		.flag_set(flag_set)
	);

	// next state: configuration access, claim decision, master gating
	always_comb begin
		s_d = s_q;
		hit = (cfg_addr[7:2] == CMD_OFS[7:2]) && pfc_func_ok(cfg_func);
		wmask = {{8{cfg_be[1]}}, {8{cfg_be[0]}}} & CMD_WR_MASK;
		acmd = pfc_func_ok(acc_func) ? s_q.cmd[acc_func] : CMD_RESET;
		mcmd = pfc_func_ok(mst_func) ? s_q.cmd[mst_func] : CMD_RESET;

		// only the addressed function's copy changes
		if (cfg_wr && hit) begin
			s_d.cmd[cfg_func] = (s_q.cmd[cfg_func] & ~wmask) |
				(cfg_wdata[15:0] & wmask); // RULE18 RULE2 RULE17 RULE4
		end

		// detected parity: write one to clear, a new error wins the race
		for (int f = 0; f < NUM_FUNC; f++) begin
			if (cfg_wr && hit && cfg_be[3] && cfg_func == 2'(f) &&
				cfg_wdata[16 + FLAG_BIT]) begin
				s_d.flag[f] = 1'b0;
			end
			if (flag_set[f]) begin
				s_d.flag[f] = 1'b1; // RULE10
			end
		end

		// read data registered one clock after the strobe
		s_d.rvalid = cfg_rd;
		s_d.rdata = 32'h0000_0000;
		if (cfg_rd && hit) begin
			s_d.rdata[15:0] = s_q.cmd[cfg_func] & CMD_WR_MASK; // RULE8 RULE12
			s_d.rdata[16 + FLAG_BIT] = s_q.flag[cfg_func];
		end

		// claim: config always, io and memory only when enabled
		s_d.claim = 1'b0;
		s_d.claim_func = acc_func;
		if (acc_valid && pfc_func_ok(acc_func)) begin
			unique case (acc_kind)
				ACC_CFG: s_d.claim = 1'b1; // RULE1
				ACC_IO: s_d.claim = acmd[IO_EN_BIT]; // RULE15
				ACC_MEM: s_d.claim = acmd[MEM_EN_BIT]; // RULE14
				ACC_OTHER: s_d.claim = 1'b0; // RULE17
			endcase
		end

		// a function without mastering starts nothing on the bus
		s_d.go = mst_req && mcmd[MASTER_BIT]; // RULE13
		s_d.mwi = mst_req && mcmd[MASTER_BIT] && mst_mwi_req &&
			mcmd[MWI_BIT]; // RULE16
	end

	// one register stage holds all state of the block except the parity checker, which keeps its own
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.cmd <= {NUM_FUNC{CMD_RESET}}; // RULE2
			s_q.flag <= {NUM_FUNC{FLAG_RESET}};
		end else begin
			s_q <= s_d;
		end
	end

	// exported enables come straight from the command flops
	always_comb begin
		for (int f = 0; f < NUM_FUNC; f++) begin
			io_space_en[f] = s_q.cmd[f][IO_EN_BIT];
			memory_space_en[f] = s_q.cmd[f][MEM_EN_BIT];
			master_en[f] = s_q.cmd[f][MASTER_BIT];
			write_invalidate_en[f] = s_q.cmd[f][MWI_BIT];
			parity_err_response[f] = s_q.cmd[f][RESP_BIT];
			system_error_drive_en[f] = s_q.cmd[f][SERR_BIT]; // RULE6
			back_to_back_en[f] = s_q.cmd[f][FBB_BIT]; // RULE4
		end
	end

	assign detected_parity_flag = s_q.flag;
	assign cfg_rdata = s_q.rdata;
	assign cfg_rvalid = s_q.rvalid;
	assign acc_claim = s_q.claim;
	assign acc_claim_func = s_q.claim_func;
	assign mst_go = s_q.go;
	assign mst_use_mwi = s_q.mwi;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	readonly_bits_a: assert property ( // RULE17
		cfg_rvalid |-> cfg_rdata[STEP_BIT] == 1'b0 &&
		cfg_rdata[VGA_BIT] == 1'b0 && cfg_rdata[SPECIAL_BIT] == 1'b0)
		else $error("read-only command bit read as one");
	detach_claim_a: assert property ( // RULE1
		acc_valid && acc_kind != ACC_CFG && acc_func == 2'h0 &&
		s_q.cmd[0] == 16'h0000 |=> !acc_claim)
		else $error("detached function claimed an access");
	cfg_claim_a: assert property ( // RULE1
		acc_valid && acc_kind == ACC_CFG && acc_func == 2'h1 |=> acc_claim)
		else $error("configuration access not claimed");
	io_claim_a: assert property ( // RULE15
		acc_valid && acc_kind == ACC_IO && acc_func == 2'h2 |=>
		acc_claim == $past(s_q.cmd[2][IO_EN_BIT]))
		else $error("io claim does not follow io enable");
	mem_claim_a: assert property ( // RULE14
		acc_valid && acc_kind == ACC_MEM && acc_func == 2'h0 |=>
		acc_claim == $past(s_q.cmd[0][MEM_EN_BIT]))
		else $error("memory claim does not follow memory enable");
	master_gate_a: assert property ( // RULE13
		mst_req && mst_func == 2'h1 |=>
		mst_go == $past(s_q.cmd[1][MASTER_BIT]))
		else $error("master start not gated by master enable");
	mwi_gate_a: assert property ( // RULE16
		mst_use_mwi |-> mst_go && $past(mcmd[MWI_BIT]))
		else $error("write-and-invalidate used while disabled");
	func_copy_a: assert property ( // RULE18
		cfg_wr && hit && cfg_func == 2'h2 && cfg_be[0] |=>
		s_q.cmd[2][7:0] == ($past(cfg_wdata[7:0]) & CMD_WR_MASK[7:0]) &&
		s_q.cmd[0] == $past(s_q.cmd[0]))
		else $error("command write missed or touched another function");
	read_answer_a: assert property ( // RULE2
		cfg_rd && hit |=> cfg_rvalid &&
		cfg_rdata[15:0] == $past(s_q.cmd[cfg_func]))
		else $error("command read back wrong");
	flag_set_wins_a: assert property ( // RULE10
		flag_set[0] |=> detected_parity_flag[0])
		else $error("detected parity flag lost");

	// every read is answered; unmapped words read zero and take no write
	rvalid_pulse_a: assert property ( // RULE2
		cfg_rvalid == $past(cfg_rd))
		else $error("read valid does not follow the read strobe");
	unmapped_zero_a: assert property ( // RULE2
		cfg_rd && !hit |=> cfg_rdata == 32'h0000_0000)
		else $error("unmapped read returned nonzero data");
	unmapped_write_a: assert property ( // RULE2
		cfg_wr && !hit |=> s_q.cmd == $past(s_q.cmd))
		else $error("write outside the command word changed a copy");

	// stored copies never hold a read-only bit, whatever was written
	readonly_store_a: assert property ( // RULE17
		((s_q.cmd[0] | s_q.cmd[1] | s_q.cmd[2]) & ~CMD_WR_MASK) == 16'h0000)
		else $error("read-only command bit stored as one");

	// byte enables pick the lanes; an unselected lane keeps its bits
	lane_keep_a: assert property ( // RULE18
		cfg_wr && hit && cfg_func == 2'h0 && !cfg_be[1] |=>
		s_q.cmd[0][15:8] == $past(s_q.cmd[0][15:8]))
		else $error("unselected byte lane of the command changed");
	fbb_write_a: assert property ( // RULE4
		cfg_wr && hit && cfg_func == 2'h1 && cfg_be[1] |=>
		back_to_back_en[1] == $past(cfg_wdata[FBB_BIT]))
		else $error("fast back-to-back enable not written");
	serr_write_a: assert property ( // RULE6
		cfg_wr && hit && cfg_func == 2'h2 && cfg_be[1] |=>
		system_error_drive_en[2] == $past(cfg_wdata[SERR_BIT]))
		else $error("system error enable not written");
	resp_write_a: assert property ( // RULE9
		cfg_wr && hit && cfg_func == 2'h1 && cfg_be[0] |=>
		parity_err_response[1] == $past(cfg_wdata[RESP_BIT]))
		else $error("parity response enable not written");

	// sticky flag: only a one written through the top lane clears it
	flag_clear_a: assert property ( // RULE10
		cfg_wr && hit && cfg_func == 2'h1 && cfg_be[3] &&
		cfg_wdata[16 + FLAG_BIT] && !flag_set[1] |=>
		!detected_parity_flag[1])
		else $error("detected parity flag not cleared");
	flag_sticky_a: assert property ( // RULE10
		detected_parity_flag[2] && !(cfg_wr && cfg_func == 2'h2) |=>
		detected_parity_flag[2])
		else $error("detected parity flag dropped on its own");

	// claims and starts only ever answer a strobe of the cycle before
	claim_needs_valid_a: assert property ( // RULE1
		acc_claim |-> $past(acc_valid))
		else $error("claim without a target access");
	other_no_claim_a: assert property ( // RULE1
		acc_valid && acc_kind == ACC_OTHER |=> !acc_claim)
		else $error("claim on an access of another kind");
	claim_func_a: assert property ( // RULE18
		acc_valid |=> acc_claim_func == $past(acc_func))
		else $error("claim names the wrong function");
	go_needs_req_a: assert property ( // RULE13
		mst_go |-> $past(mst_req))
		else $error("master start without a request");
	no_master_quiet_a: assert property ( // RULE13
		master_en == 3'h0 |=> !mst_go)
		else $error("master start while no function may master");
endmodule

// ==== pfc_host.sv ====
/*
 * Host model: configuration software issuing config writes and reads.
 * Assumes the block takes each strobe on a rising edge of mclk.
 */
`timescale 1ns/1ps
module pfc_host (
	input wire logic mclk,
	output logic cfg_wr,
	output logic cfg_rd,
	output logic [1:0] cfg_func,
	output logic [7:0] cfg_addr,
	output logic [3:0] cfg_be,
	output logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata,
	input wire logic cfg_rvalid
);
	// idle bus: strobes low, data lines hold no meaningful value
	initial begin
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		cfg_func = 2'h0;
		cfg_addr = 8'h00;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0000_0000;
	end

	// one write; software assumes all targets can do fast back-to-back
	task automatic wr(input logic [1:0] f, input logic [7:0] a,
		input logic [3:0] be, input logic [31:0] d);
		@(negedge mclk);
		cfg_wr = 1'b1;
		cfg_func = f;
		cfg_addr = a;
		cfg_be = be;
		cfg_wdata = d & 32'hFFFF_03FF;
		@(negedge mclk);
		cfg_wr = 1'b0;
		cfg_wdata = ~cfg_wdata;
	endtask

	// one read; a missing valid pulse yields unknown data
	task automatic rd(input logic [1:0] f, input logic [7:0] a,
		output logic [31:0] d);
		@(negedge mclk);
		cfg_rd = 1'b1;
		cfg_func = f;
		cfg_addr = a;
		@(negedge mclk);
		cfg_rd = 1'b0;
		d = (cfg_rvalid === 1'b1) ? cfg_rdata : 32'hXXXX_XXXX;
	endtask
endmodule

// ==== pfc_parity.sv ====
/*
 * Bus parity generator and checker shared by all functions.
 * Assumes ad/cbe and the phase strobes arrive synchronous to mclk, and
 * that par_in for a phase arrives one clock after that phase.
 */
`timescale 1ns/1ps
module pfc_parity
	import pfc_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [31:0] ad,
	input wire logic [3:0] cbe,
	input wire logic par_in,
	input wire logic addr_phase,
	input wire logic data_phase,
	input wire logic [1:0] phase_func,
	input wire logic [2:0] resp_en,
	input wire logic [2:0] serr_en,
	output logic par_o,
	output logic perr_n_o,
	output logic perr_oe,
	output logic serr_n_o,
	output logic serr_oe,
	output logic [2:0] flag_set
);
	import pfc_pkg::*;

	typedef struct packed {
		logic [31:0] ad;
		logic [3:0] cbe;
		logic addr;
		logic data;
		logic [1:0] func;
		logic par;
		logic perr;
		logic serr;
		logic [2:0] flag;
	} pfc_par_state_t;

	pfc_par_state_t s_q, s_d;
	logic bad;
	logic fok;

	// parity of a phase leaves two clocks after that phase, one clock after its par_in
	always_comb begin
		s_d = s_q;
		s_d.ad = ad;
		s_d.cbe = cbe;
		s_d.addr = addr_phase;
		s_d.data = data_phase;
		s_d.func = phase_func;
		s_d.par = pfc_parity(s_q.ad, s_q.cbe); // RULE11
		bad = (par_in != pfc_parity(s_q.ad, s_q.cbe));
		fok = pfc_func_ok(s_q.func);
		s_d.perr = 1'b0;
		s_d.serr = 1'b0;
		s_d.flag = 3'h0;
		if (bad && fok && (s_q.addr || s_q.data)) begin
			// the flag is set whatever the response setting
			s_d.flag[s_q.func] = 1'b1; // RULE10
			// data errors only signal when responses are enabled
			s_d.perr = s_q.data && resp_en[s_q.func]; // RULE9 RULE10
			// address errors need both enables before they are reported
			s_d.serr = s_q.addr && resp_en[s_q.func] &&
				serr_en[s_q.func]; // RULE7 RULE6
		end
	end

	// single register stage for all parity state
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign par_o = s_q.par;
	assign perr_n_o = ~s_q.perr;
	assign perr_oe = s_q.perr;
	assign serr_n_o = ~s_q.serr;
	assign serr_oe = s_q.serr;
	assign flag_set = s_q.flag;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	par_follows_ad_a: assert property ( // RULE11
		par_o == pfc_parity($past(ad, 2), $past(cbe, 2)))
		else $error("parity output does not match the phase before");
	perr_needs_resp_a: assert property ( // RULE10
		!perr_oe || $past(resp_en[s_q.func]))
		else $error("parity error driven with response disabled");
	serr_needs_both_a: assert property ( // RULE7
		serr_oe |-> $past(resp_en[s_q.func] && serr_en[s_q.func]))
		else $error("system error driven without both enables");
endmodule

// ==== pfc_pkg.sv ====
/*
 * Shared constants and types for the per-function PCI command register:
 * configuration offset, bit positions, reset and write masks, access kinds.
 * Assumes a 32-bit configuration data path with four byte enables.
 */
package pfc_pkg;

	// three controller functions behind one bus interface
	localparam int NUM_FUNC = 3;

	// configuration dword holding command (low half) and status (high half)
	localparam logic [7:0] CMD_OFS = 8'h04;

	// command bit positions
	localparam int IO_EN_BIT = 0;
	localparam int MEM_EN_BIT = 1;
	localparam int MASTER_BIT = 2;
	localparam int SPECIAL_BIT = 3;
	localparam int MWI_BIT = 4;
	localparam int VGA_BIT = 5;
	localparam int RESP_BIT = 6;
	localparam int STEP_BIT = 7;
	localparam int SERR_BIT = 8;
	localparam int FBB_BIT = 9;

	// status bit position of the detected parity flag
	localparam int FLAG_BIT = 15;

	// reset value and mask of bits that hold what software writes
	localparam logic [15:0] CMD_RESET = 16'h0000;
	localparam logic [15:0] CMD_WR_MASK = 16'hFF57;
	localparam logic FLAG_RESET = 1'b0;

	// kinds of bus access that a function may be asked to claim
	typedef enum logic [1:0] {
		ACC_CFG,
		ACC_IO,
		ACC_MEM,
		ACC_OTHER
	} pfc_acc_t;

	// even parity over one address/data phase
	function automatic logic pfc_parity(input logic [31:0] ad,
		input logic [3:0] cbe);
		pfc_parity = ^{ad, cbe};
	endfunction

	// true when a function number names one of the implemented functions
	function automatic logic pfc_func_ok(input logic [1:0] f);
		pfc_func_ok = (f < 2'(NUM_FUNC));
	endfunction

endpackage

// ==== testbench.sv ====
/*
 * Self-checking bench for the per-function command registers.
 * Assumes the host model drives the config strobes; bench drives the rest.
 */
`timescale 1ns/1ps
module testbench;
	import pfc_pkg::*;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic cfg_wr, cfg_rd, cfg_rvalid;
	logic [1:0] cfg_func, acc_func, acc_claim_func, mst_func, phase_func;
	logic [7:0] cfg_addr;
	logic [3:0] cfg_be, cbe;
	logic [31:0] cfg_wdata, cfg_rdata, ad, d;
	logic acc_valid, acc_claim, mst_req, mst_mwi_req, mst_go, mst_use_mwi;
	pfc_acc_t acc_kind;
	logic [2:0] io_space_en, memory_space_en, master_en, write_invalidate_en;
	logic [2:0] parity_err_response, system_error_drive_en, back_to_back_en;
	logic [2:0] detected_parity_flag;
	logic par_in, addr_phase, data_phase, par_o;
	logic perr_n_o, perr_oe, serr_n_o, serr_oe;
	logic c;
	int n_errors = 0;
	int n_tests = 0;

	pfc_cmd_regs dut (.mclk, .sys_rst, .cfg_wr, .cfg_rd, .cfg_func,
		.cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rvalid, .acc_valid,
		.acc_func, .acc_kind, .acc_claim, .acc_claim_func, .mst_req,
		.mst_mwi_req, .mst_func, .mst_go, .mst_use_mwi, .io_space_en,
		.memory_space_en, .master_en, .write_invalidate_en,
		.parity_err_response, .system_error_drive_en, .back_to_back_en,
		.detected_parity_flag, .ad, .cbe, .par_in, .addr_phase, .data_phase,
		.phase_func, .par_o, .perr_n_o, .perr_oe, .serr_n_o, .serr_oe);

	pfc_host host (.mclk, .cfg_wr, .cfg_rd, .cfg_func, .cfg_addr, .cfg_be,
		.cfg_wdata, .cfg_rdata, .cfg_rvalid);

	// free-running clock, 10 ns period
	always #5 mclk = ~mclk;

	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_of_test();
		if (n_errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// one target access; the claim stands for one cycle only
	task automatic acc(input logic [1:0] f, input pfc_acc_t k,
		output logic cl);
		@(negedge mclk);
		acc_valid = 1'b1;
		acc_func = f;
		acc_kind = k;
		@(negedge mclk);
		acc_valid = 1'b0;
		cl = acc_claim;
		check("claim func", acc_claim_func, f);
	endtask

	// master request, checks start and write-and-invalidate grants
	task automatic mst(input logic [1:0] f, input logic mwi,
		input logic [1:0] exp);
		@(negedge mclk);
		mst_req = 1'b1;
		mst_mwi_req = mwi;
		mst_func = f;
		@(negedge mclk);
		mst_req = 1'b0;
		check("mst go/mwi", {mst_go, mst_use_mwi}, exp);
	endtask

	// one bus phase, parity given one clock later, results two clocks on
	task automatic phase(input logic [1:0] f, input logic adr,
		input logic bad, input logic pe, input logic se);
		logic p;
		@(negedge mclk);
		ad = {f, 30'h1234_5A7C} ^ {32{bad}};
		cbe = 4'h6;
		phase_func = f;
		addr_phase = adr;
		data_phase = !adr;
		p = ^{ad, cbe};
		@(negedge mclk);
		addr_phase = 1'b0;
		data_phase = 1'b0;
		par_in = p ^ bad;
		@(negedge mclk);
		check("par_o", par_o, p);
		check("perr", {perr_oe, perr_n_o}, pe ? 2'b10 : 2'b01);
		check("serr", {serr_oe, serr_n_o}, se ? 2'b10 : 2'b01);
		@(negedge mclk); // the sticky flag lands one stage after the pulse
		check("flag", detected_parity_flag[f], bad);
	endtask

	// all zero after reset: only configuration accesses claimed
	task automatic t_reset();
		for (int f = 0; f < 3; f++) begin
			host.rd(2'(f), 8'h04, d);
			check("cmd reset", d, 32'h0000_0000);
			acc(2'(f), ACC_IO, c);
			check("claim io", c, 1'b0);
			acc(2'(f), ACC_MEM, c);
			check("claim mem", c, 1'b0);
			acc(2'(f), ACC_CFG, c);
			check("claim cfg", c, 1'b1);
		end
		mst(2'h0, 1'b1, 2'b00);
	endtask

	// writes land only in the named function and mapped offset
	task automatic t_write();
		host.wr(2'h1, 8'h04, 4'h3, 32'h0000_03FF);
		host.rd(2'h1, 8'h04, d);
		check("cmd f1", d, 32'h0000_0357);
		check("fbb", back_to_back_en, 3'b010);
		check("serr en", system_error_drive_en, 3'b010);
		check("io en", io_space_en, 3'b010);
		check("mem en", memory_space_en, 3'b010);
		check("master en", master_en, 3'b010);
		check("mwi en", write_invalidate_en, 3'b010);
		check("resp en", parity_err_response, 3'b010);
		host.rd(2'h0, 8'h04, d);
		check("cmd f0", d, 32'h0000_0000);
		host.wr(2'h2, 8'h08, 4'h3, 32'h0000_0103);
		host.rd(2'h2, 8'h08, d);
		check("unmapped", d, 32'h0000_0000);
		host.rd(2'h2, 8'h04, d);
		check("cmd f2", d, 32'h0000_0000);
		host.wr(2'h2, 8'h04, 4'h3, 32'h0000_0100);
		host.wr(2'h0, 8'h04, 4'h1, 32'h0000_0004);
	endtask

	// claims and master grants follow each function's own bits
	task automatic t_gate();
		check("master en2", master_en, 3'b011);
		check("serr en2", system_error_drive_en, 3'b110);
		acc(2'h1, ACC_IO, c);
		check("f1 io", c, 1'b1);
		acc(2'h1, ACC_MEM, c);
		check("f1 mem", c, 1'b1);
		acc(2'h1, ACC_OTHER, c);
		check("f1 other", c, 1'b0);
		acc(2'h2, ACC_MEM, c);
		check("f2 mem", c, 1'b0);
		mst(2'h1, 1'b1, 2'b11);
		mst(2'h0, 1'b1, 2'b10);
		mst(2'h2, 1'b0, 2'b00);
	endtask

	// parity detection per function, then clear the sticky flag
	task automatic t_parity();
		phase(2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
		phase(2'h0, 1'b0, 1'b1, 1'b0, 1'b0);
		phase(2'h1, 1'b0, 1'b1, 1'b1, 1'b0);
		phase(2'h1, 1'b1, 1'b1, 1'b0, 1'b1);
		phase(2'h2, 1'b1, 1'b1, 1'b0, 1'b0);
		host.rd(2'h1, 8'h04, d);
		check("flag rd", d, 32'h8000_0357);
		host.wr(2'h1, 8'h04, 4'h8, 32'h8000_0000);
		host.rd(2'h1, 8'h04, d);
		check("flag clr", d, 32'h0000_0357);
	endtask

	// main sequence
	initial begin
		{acc_valid, mst_req, mst_mwi_req, par_in, addr_phase, data_phase} =
			6'h00;
		{acc_func, mst_func, phase_func} = 6'h00;
		acc_kind = ACC_CFG;
		ad = 32'h0000_0000;
		cbe = 4'h0;
		repeat (20) @(negedge mclk);
		sys_rst = 1'b0;
		t_reset();
		t_write();
		t_gate();
		t_parity();
		end_of_test();
	end

	// watchdog well beyond the roughly one hundred cycles the tests need
	initial begin
		#50000;
		n_errors++;
		end_of_test();
	end
endmodule
